// file: smc_fifo.sv
`timescale 1ns/100ps
`include "smc_params.svh"

module smc_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = `SMC_FIFO_DEPTH,
    parameter int AW    = `SMC_FIFO_AW
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    // fill level
    output logic [AW:0]           level_o
);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } smc_fifo_state_t;

    smc_fifo_state_t  st_ff;
    smc_fifo_state_t  nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_o  = (st_ff.cnt != DEPTH[AW:0]);
    assign out_valid_o = (st_ff.cnt != '0);
    assign out_data_o  = mem_ff[st_ff.rd];
    assign level_o     = st_ff.cnt;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // storage has no reset; only pointers guard it
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[st_ff.wr] <= in_data_i;
        end
    end

endmodule

// file: smc_mailbox.sv
// Behaviour
// [R01] packets are one header word then zero or more argument words, nothing else
// [R02] header: tag 27:24, arg count 22:12, flag 11, code 10:0, rest reserved
// [R03] response header carries the command's tag back, unchanged by this block
// [R04] host keeps header bit 11 zero in commands
// [R05] code 0 no-op, 10 ident word, 12 unique id two words low first
// [R06] code 18 voltage per mask bit, unsigned sixteen fraction bits
// [R07] code 19 temperature per channel, signed eight fraction bits, channel 0 core
// [R08] code 32 grabs flash interface if free, 33 releases it
// [R09] code 34 chip select in argument bits 31:28, lower bits zero
// [R10] code 3a flash read offset and count, at most four kilobytes
// [R11] code 39 flash write offset, count, data; ok reply without arguments
// [R12] code 38 erase sector-aligned offset, byte count multiple of 64 KB
// [R13] codes 35/36/37 flash register read, write, lone opcode; zero padding
// [R14] response codes 0,1,2,3,256,511,767,1023 as listed in the header
// [R15] word 0 pushes command word, word 1 pushes final word with end marker
// [R16] word 2 reads command free space, word 3 pushes urgent, word 4 urgent space
// [R17] word 5 pops response, word 6 gives level, end bit 1, start bit 0
// [R18] word 7 enable bits reset 0: bit 1 command not full, bit 0 response
// [R19] cleared enable only masks interrupt, status still visible
// [R20] word 8 read-only status: bit 1 command not full, bit 0 response present
// [R21] status follows fifo activity only, writes cannot clear it
// [R22] header-only command is a single write to word 1
// [R23] command writes while fifo is full are dropped
// [R24] host polls word 6 for start, reads header, then count argument words
// [R25] interrupt is OR over sources of status AND enable per source, every cycle
// [R26] reads answered one cycle later with a valid pulse; word 5 read pops
// [R27] commands leave as marked stream; responses stored with markers
`timescale 1ns/100ps
`include "smc_params.svh"

module smc_mailbox (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // host register port
    input  wire logic [3:0]  reg_address_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    input  wire logic [31:0] reg_writedata_i,
    output logic      [31:0] reg_readdata_o,
    output logic             reg_readdatavalid_o,
    // interrupt
    output logic             irq_o,
    // command stream to manager
    output logic             cmd_valid_o,
    input  wire logic        cmd_ready_i,
    output logic      [31:0] cmd_data_o,
    output logic             cmd_sop_o,
    output logic             cmd_eop_o,
    output logic             cmd_urgent_o,
    // response stream from manager
    input  wire logic        rsp_valid_i,
    output logic             rsp_ready_o,
    input  wire logic [31:0] rsp_data_i,
    input  wire logic        rsp_sop_i,
    input  wire logic        rsp_eop_i
);

    localparam int BW = 34;

    smc_pkg::smc_top_state_t st_ff;
    smc_pkg::smc_top_state_t nxt_st;

    smc_pkg::smc_beat_t      cmd_in;
    smc_pkg::smc_beat_t      urg_in;
    smc_pkg::smc_beat_t      rsp_in;
    smc_pkg::smc_beat_t      cmd_out;
    smc_pkg::smc_beat_t      urg_out;
    smc_pkg::smc_beat_t      rsp_out;

    logic                    cmd_push;
    logic                    urg_push;
    logic                    cmd_in_ready;
    logic                    urg_in_ready;
    logic                    cmd_has;
    logic                    urg_has;
    logic                    cmd_take;
    logic                    urg_take;
    logic                    rsp_has;
    logic                    rsp_pop;
    logic [`SMC_LVL_W-1:0]   cmd_lvl;
    logic [`SMC_LVL_W-1:0]   urg_lvl;
    logic [`SMC_LVL_W-1:0]   rsp_lvl;
    logic [1:0]              flags;
    logic [`SMC_LVL_W-1:0]   depth_c;

    // outgoing stream register
    logic                    out_valid_ff;
    smc_pkg::smc_beat_t      out_beat_ff;
    logic                    out_urg_ff;
    logic                    out_load;

    assign depth_c = `SMC_LVL_W'(`SMC_FIFO_DEPTH);

    // full fifo drops the write: push is qualified by ready
    assign cmd_push = reg_write_i && cmd_in_ready &&
                      (reg_address_i == `SMC_REG_CMD ||
                       reg_address_i == `SMC_REG_CMD_LAST); // [R15] [R23]
    assign urg_push = reg_write_i && urg_in_ready &&
                      (reg_address_i == `SMC_REG_URG); // [R16] [R23]

    // command start marker is derived from packet position, end from the write offset
    always_comb begin
        cmd_in      = '0;
        // header and argument words pass untouched; codes are the manager's business
        cmd_in.data = reg_writedata_i; // [R02] [R05] [R06] [R07] [R08] [R09]
        cmd_in.eop  = (reg_address_i == `SMC_REG_CMD_LAST); // [R15] [R22]
        urg_in      = '0;
        urg_in.data = reg_writedata_i;
        urg_in.eop  = 1'b1;
        urg_in.packet_first_marker = 1'b1;
        rsp_in.data = rsp_data_i; // [R10] [R11] [R12] [R13] [R14]
        rsp_in.eop  = rsp_eop_i;
        rsp_in.packet_first_marker = rsp_sop_i; // [R27]
    end

    smc_fifo #(.WIDTH(BW)) u_cmd_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (cmd_push),
        .in_ready_o  (cmd_in_ready),
        .in_data_i   (cmd_in),
        .out_valid_o (cmd_has),
        .out_ready_i (cmd_take),
        .out_data_o  (cmd_out),
        .level_o     (cmd_lvl)
    );

    // urgent words are single-word packets
    smc_fifo #(.WIDTH(BW)) u_urg_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (urg_push),
        .in_ready_o  (urg_in_ready),
        .in_data_i   (urg_in),
        .out_valid_o (urg_has),
        .out_ready_i (urg_take),
        .out_data_o  (urg_out),
        .level_o     (urg_lvl)
    );

    smc_fifo #(.WIDTH(BW)) u_rsp_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (rsp_valid_i),
        .in_ready_o  (rsp_ready_o),
        .in_data_i   (rsp_in),
        .out_valid_o (rsp_has),
        .out_ready_i (rsp_pop),
        .out_data_o  (rsp_out),
        .level_o     (rsp_lvl)
    );

    assign rsp_pop = reg_read_i && (reg_address_i == `SMC_REG_RSP_DATA); // [R26]

    // status is raw fifo state, no storage that a write could touch
    assign flags[`SMC_IRQ_CMD_NOT_FULL] = cmd_in_ready; // [R20] [R21]
    assign flags[`SMC_IRQ_RSP_VALID]    = rsp_has; // [R20] [R21]

    // arbiter: urgent wins, but never splits a normal packet in flight
    assign out_load = !out_valid_ff || cmd_ready_i;
    always_comb begin
        urg_take = 1'b0;
        cmd_take = 1'b0;
        if (out_load) begin
            if (st_ff.sop_next && urg_has) begin
                urg_take = 1'b1;
            end else if (cmd_has) begin
                cmd_take = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_ff <= 1'b0;
            out_beat_ff  <= '0;
            out_urg_ff   <= 1'b0;
        end else if (out_load) begin
            out_valid_ff <= urg_take || cmd_take;
            out_urg_ff   <= urg_take;
            if (urg_take) begin
                out_beat_ff <= urg_out;
            end else begin
                out_beat_ff.data <= cmd_out.data;
                out_beat_ff.eop  <= cmd_out.eop;
                out_beat_ff.packet_first_marker <= st_ff.sop_next; // [R27] [R01]
            end
        end
    end

    assign cmd_valid_o  = out_valid_ff; // [R27]
    assign cmd_data_o   = out_beat_ff.data;
    assign cmd_sop_o    = out_beat_ff.packet_first_marker;
    assign cmd_eop_o    = out_beat_ff.eop;
    assign cmd_urgent_o = out_urg_ff;

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.rd_valid = reg_read_i; // [R26]
        nxt_st.rd_data  = '0;
        nxt_st.irq      = |(flags & st_ff.irq_mask); // [R25] [R19]
        if (cmd_take) begin
            nxt_st.sop_next = cmd_out.eop;
            nxt_st.src      = cmd_out.eop ? smc_pkg::SMC_SRC_IDLE : smc_pkg::SMC_SRC_NORMAL;
        end else if (urg_take) begin
            nxt_st.src = smc_pkg::SMC_SRC_URGENT;
        end
        if (reg_write_i && reg_address_i == `SMC_REG_IRQ_MASK) begin
            nxt_st.irq_mask = reg_writedata_i[1:0]; // [R18]
        end
        if (reg_read_i) begin
            unique case (reg_address_i)
                `SMC_REG_CMD_FREE: begin
                    nxt_st.rd_data = 32'(depth_c - cmd_lvl); // [R16]
                end
                `SMC_REG_URG_FREE: begin
                    nxt_st.rd_data = 32'(depth_c - urg_lvl); // [R16]
                end
                `SMC_REG_RSP_DATA: begin
                    nxt_st.rd_data = rsp_has ? rsp_out.data : 32'h0; // [R17] [R03]
                end
                `SMC_REG_RSP_LEVEL: begin
                    nxt_st.rd_data[`SMC_LVL_COUNT_LSB +: `SMC_LVL_W] = rsp_lvl; // [R17]
                    nxt_st.rd_data[`SMC_LVL_EOP] = rsp_has && rsp_out.eop;
                    nxt_st.rd_data[`SMC_LVL_SOP] = rsp_has && rsp_out.packet_first_marker;
                end
                `SMC_REG_IRQ_MASK: begin
                    nxt_st.rd_data[1:0] = st_ff.irq_mask; // [R18]
                end
                `SMC_REG_IRQ_FLAGS: begin
                    nxt_st.rd_data[1:0] = flags; // [R19] [R20]
                end
                default: begin
                    nxt_st.rd_data = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff          <= '0;
            st_ff.irq_mask <= `SMC_IRQ_MASK_RESET;
            st_ff.src      <= smc_pkg::SMC_SRC_IDLE;
            st_ff.sop_next <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_readdata_o      = st_ff.rd_data;
    assign reg_readdatavalid_o = st_ff.rd_valid;
    assign irq_o               = st_ff.irq;

endmodule

// file: smc_mailbox_chk.sv
`timescale 1ns/100ps
`include "smc_params.svh"

module smc_mailbox_chk (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // host port
    input wire logic [3:0]  reg_address_i,
    input wire logic        reg_write_i,
    input wire logic        reg_read_i,
    input wire logic [31:0] reg_writedata_i,
    input wire logic [31:0] reg_readdata_o,
    input wire logic        reg_readdatavalid_o,
    input wire logic        irq_o,
    // command stream
    input wire logic        cmd_valid_o,
    input wire logic        cmd_ready_i,
    input wire logic [31:0] cmd_data_o,
    input wire logic        cmd_sop_o,
    input wire logic        cmd_eop_o,
    input wire logic        cmd_urgent_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // tracks whether a packet is open on the command stream
    logic in_pkt_ff;
    logic nxt_in_pkt;
    always_comb begin
        nxt_in_pkt = in_pkt_ff;
        if (cmd_valid_o && cmd_ready_i)
            nxt_in_pkt = !cmd_eop_o;
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            in_pkt_ff <= 1'b0;
        else
            in_pkt_ff <= nxt_in_pkt;
    end

    property p_rd_lat;
        reg_read_i |=> reg_readdatavalid_o;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
    property p_rd_only;
        reg_readdatavalid_o |-> $past(reg_read_i);
    endproperty
    a_rd_only: assert property (p_rd_only) else $error("stray read valid");
    property p_rd_idle;
        !reg_readdatavalid_o |-> reg_readdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_flags;
        reg_read_i && reg_address_i == `SMC_REG_IRQ_FLAGS |=> reg_readdata_o[31:2] == 30'h0;
    endproperty
    a_flags: assert property (p_flags) else $error("status upper bits set");
    property p_free;
        reg_read_i && reg_address_i == `SMC_REG_CMD_FREE |=> reg_readdata_o <= 32'h4;
    endproperty
    a_free: assert property (p_free) else $error("free space too large");
    property p_mask_off;
        reg_write_i && reg_address_i == `SMC_REG_IRQ_MASK && reg_writedata_i[1:0] == 2'h0
            |=> ##1 !irq_o;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq while masked");
    property p_hold;
        cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_data_o)
            && $stable(cmd_sop_o) && $stable(cmd_eop_o);
    endproperty
    a_hold: assert property (p_hold) else $error("command beat changed");
    property p_urg;
        cmd_valid_o && cmd_urgent_o |-> cmd_sop_o && cmd_eop_o;
    endproperty
    a_urg: assert property (p_urg) else $error("urgent beat not whole");
    property p_sop;
        cmd_valid_o |-> cmd_sop_o == !in_pkt_ff;
    endproperty
    a_sop: assert property (p_sop) else $error("start marker misplaced");
endmodule

bind smc_mailbox smc_mailbox_chk u_chk (
    .clk_i, .resetn_i, .reg_address_i, .reg_write_i, .reg_read_i,
    .reg_writedata_i, .reg_readdata_o, .reg_readdatavalid_o, .irq_o,
    .cmd_valid_o, .cmd_ready_i, .cmd_data_o, .cmd_sop_o, .cmd_eop_o, .cmd_urgent_o
);

// file: smc_mgr_model.sv
`timescale 1ns/100ps
`include "smc_params.svh"

module smc_mgr_model #(
    parameter logic [31:0] IDENT = 32'h1234_5678 // arbitrary value
) (
    // clock and stall
    input  wire logic        clk_i,
    input  wire logic        stall_i,
    // command stream in
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [31:0] cmd_data_i,
    input  wire logic        cmd_sop_i,
    input  wire logic        cmd_eop_i,
    // response stream out
    output logic             rsp_valid_o,
    input  wire logic        rsp_ready_i,
    output logic [31:0]      rsp_data_o,
    output logic             rsp_sop_o,
    output logic             rsp_eop_o
);
    logic [33:0] q[$];
    logic [3:0]  tag;
    logic [10:0] code;
    assign cmd_ready_o = !stall_i;
    initial begin
        rsp_valid_o = 1'b0;
        rsp_data_o  = 32'h0;
        rsp_sop_o   = 1'b0;
        rsp_eop_o   = 1'b0;
    end
    always @(posedge clk_i) begin
        if (rsp_valid_o && rsp_ready_i)
            void'(q.pop_front());
        if (cmd_valid_i && cmd_ready_o && cmd_sop_i) begin
            tag  = cmd_data_i[27:24];
            code = cmd_data_i[10:0];
        end
        if (cmd_valid_i && cmd_ready_o && cmd_eop_i) begin
            if (code == `SMC_CODE_NO_OPERATION_CMD)
                q.push_back({2'b11, 4'h0, tag, 1'b0, 11'd0, 1'b0, `SMC_RSP_OK});
            else begin
                q.push_back({2'b10, 4'h0, tag, 1'b0, 11'd1, 1'b0, `SMC_RSP_OK});
                q.push_back({2'b01, IDENT});
            end
        end
        if (q.size() > 0) begin
            rsp_valid_o <= 1'b1;
            {rsp_sop_o, rsp_eop_o, rsp_data_o} <= q[0];
        end else begin
            // released lines must not keep showing the last word
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= ~rsp_data_o;
        end
    end
endmodule

// file: smc_params.svh
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// register word indices
`define SMC_REG_CMD          4'h0
`define SMC_REG_CMD_LAST     4'h1
`define SMC_REG_CMD_FREE     4'h2
`define SMC_REG_URG          4'h3
`define SMC_REG_URG_FREE     4'h4
`define SMC_REG_RSP_DATA     4'h5
`define SMC_REG_RSP_LEVEL    4'h6
`define SMC_REG_IRQ_MASK     4'h7
`define SMC_REG_IRQ_FLAGS    4'h8

// irq bit positions and reset
`define SMC_IRQ_CMD_NOT_FULL 1
`define SMC_IRQ_RSP_VALID    0
`define SMC_IRQ_MASK_RESET   2'h0

// response level register fields
`define SMC_LVL_EOP          1
`define SMC_LVL_SOP          0
`define SMC_LVL_COUNT_LSB    2

// header fields
`define SMC_HDR_TAG_MSB      27
`define SMC_HDR_TAG_LSB      24
`define SMC_HDR_LEN_MSB      22
`define SMC_HDR_LEN_LSB      12
`define SMC_HDR_FLAG_BIT     11
`define SMC_HDR_CODE_MSB     10

// command codes
`define SMC_CODE_NO_OPERATION_CMD        11'h000
`define SMC_CODE_IDENT       11'h010
`define SMC_CODE_UNIQUE_ID   11'h012
`define SMC_CODE_VOLTAGE     11'h018
`define SMC_CODE_TEMP        11'h019
`define SMC_CODE_FLASH_OPEN  11'h032
`define SMC_CODE_FLASH_CLOSE 11'h033
`define SMC_CODE_FLASH_CS    11'h034
`define SMC_CODE_FLASH_RREG  11'h035
`define SMC_CODE_FLASH_WREG  11'h036
`define SMC_CODE_FLASH_OP    11'h037
`define SMC_CODE_FLASH_ERASE 11'h038
`define SMC_CODE_FLASH_WRITE 11'h039
`define SMC_CODE_FLASH_READ  11'h03a

// response codes
`define SMC_RSP_OK           11'd0
`define SMC_RSP_MALFORMED    11'd1
`define SMC_RSP_UNK_BOOT     11'd2
`define SMC_RSP_UNK_FW       11'd3
`define SMC_RSP_UNCONFIG     11'd256
`define SMC_RSP_BUSY         11'd511
`define SMC_RSP_NO_RESP      11'd767
`define SMC_RSP_ERROR        11'd1023

// fifo geometry
`define SMC_FIFO_DEPTH       4
`define SMC_FIFO_AW          2
`define SMC_LVL_W            3

`endif

// file: smc_pkg.sv
package smc_pkg;

    typedef struct packed {
        logic [3:0]  rsvd;
        logic [3:0]  request_tag;
        logic        rsvd0;
        logic [10:0] arg_count;
        logic        flag;
        logic [10:0] code;
    } smc_header_t;

    typedef struct packed {
        logic        packet_first_marker;
        logic        eop;
        logic [31:0] data;
    } smc_beat_t;

    typedef enum logic [1:0] {
        SMC_SRC_IDLE,
        SMC_SRC_URGENT,
        SMC_SRC_NORMAL
    } smc_src_t;

    typedef struct packed {
        logic [1:0]  irq_mask;
        logic        irq;
        logic        rd_valid;
        logic [31:0] rd_data;
        smc_src_t    src;
        logic        sop_next;
    } smc_top_state_t;

endpackage

// file: tb_top.sv
`timescale 1ns/100ps
`include "smc_params.svh"

module tb_top;
    localparam logic [31:0] IDENT = 32'h1234_5678;
    logic        clk_i, resetn_i, reg_write_i, reg_read_i, stall;
    logic [3:0]  reg_address_i;
    logic [31:0] reg_writedata_i, reg_readdata_o, cmd_data_o, rsp_data_i, d;
    logic        reg_readdatavalid_o, irq_o, cmd_valid_o, cmd_ready_i;
    logic        cmd_sop_o, cmd_eop_o, cmd_urgent_o;
    logic        rsp_valid_i, rsp_ready_o, rsp_sop_i, rsp_eop_i;
    int          fail_count, n_compared, n;
    logic [34:0] beats[$];

    smc_mailbox u_dut (.clk_i, .resetn_i, .reg_address_i, .reg_write_i, .reg_read_i,
        .reg_writedata_i, .reg_readdata_o, .reg_readdatavalid_o, .irq_o, .cmd_valid_o,
        .cmd_ready_i, .cmd_data_o, .cmd_sop_o, .cmd_eop_o, .cmd_urgent_o, .rsp_valid_i,
        .rsp_ready_o, .rsp_data_i, .rsp_sop_i, .rsp_eop_i);
    smc_mgr_model #(.IDENT(IDENT)) u_mgr (.clk_i, .stall_i(stall), .cmd_valid_i(cmd_valid_o),
        .cmd_ready_o(cmd_ready_i), .cmd_data_i(cmd_data_o), .cmd_sop_i(cmd_sop_o),
        .cmd_eop_i(cmd_eop_o), .rsp_valid_o(rsp_valid_i), .rsp_ready_i(rsp_ready_o),
        .rsp_data_o(rsp_data_i), .rsp_sop_o(rsp_sop_i), .rsp_eop_o(rsp_eop_i));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (cmd_valid_o && cmd_ready_i)
            beats.push_back({cmd_urgent_o, cmd_sop_o, cmd_eop_o, cmd_data_o});

    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_write_i     <= 1'b1;
        reg_address_i   <= a;
        reg_writedata_i <= v;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        reg_read_i    <= 1'b1;
        reg_address_i <= a;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1;
        chk(reg_readdatavalid_o, 35'h1);
        d = reg_readdata_o;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    // bounded poll; running out ends the run as a failure
    task automatic poll(input logic [3:0] a, input logic [31:0] e);
        for (int i = 0; i < 60; i++) begin
            rd(a);
            if (d === e)
                return;
        end
        chk(d, e);
        finish_test();
    endtask

    initial begin
        resetn_i        = 1'b0;
        reg_address_i   = 4'h0;
        reg_write_i     = 1'b0;
        reg_read_i      = 1'b0;
        reg_writedata_i = 32'h0;
        stall           = 1'b1;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rdc(`SMC_REG_IRQ_FLAGS, 32'h2);
        rdc(`SMC_REG_IRQ_MASK, 32'h0);
        rdc(`SMC_REG_CMD_FREE, 32'h4);
        rdc(`SMC_REG_URG_FREE, 32'h4);
        rdc(`SMC_REG_RSP_LEVEL, 32'h0);
        rdc(`SMC_REG_RSP_DATA, 32'h0);
        chk(rsp_ready_o, 35'h1);
        rdc(4'h9, 32'h0);
        wr(`SMC_REG_IRQ_FLAGS, 32'h0);
        rdc(`SMC_REG_IRQ_FLAGS, 32'h2);
        wr(`SMC_REG_IRQ_MASK, 32'h3);
        rdc(`SMC_REG_IRQ_MASK, 32'h3);
        chk(irq_o, 35'h1);
        $display("test registers done");
        // manager stalled: fill until the free space runs out
        n = 0;
        for (int i = 0; i < 8; i++) begin
            rd(`SMC_REG_CMD_FREE);
            if (d === 32'h0)
                break;
            wr(d === 32'h1 ? `SMC_REG_CMD_LAST : `SMC_REG_CMD,
               n == 0 ? 32'h0500_4010 : 32'ha0 + n);
            n++;
        end
        chk(d, 35'h0);
        // fifo words plus the one beat staged at the stream output
        chk(n, `SMC_FIFO_DEPTH + 1);
        rdc(`SMC_REG_IRQ_FLAGS, 32'h0);
        chk(irq_o, 35'h0);
        wr(`SMC_REG_CMD_LAST, 32'hdead_0001);
        wr(`SMC_REG_URG, 32'h0900_0000);
        rdc(`SMC_REG_URG_FREE, 32'h3);
        stall <= 1'b0;
        poll(`SMC_REG_RSP_LEVEL, 32'hd);
        chk(beats.size(), n + 1);
        for (int i = 0; i < n; i++)
            chk(beats[i], {1'b0, i == 0, i == n - 1,
                           i == 0 ? 32'h0500_4010 : 32'ha0 + i});
        chk(beats[n], {3'b111, 32'h0900_0000});
        rdc(`SMC_REG_IRQ_FLAGS, 32'h3);
        rdc(`SMC_REG_RSP_DATA, 32'h0500_1000);
        rdc(`SMC_REG_RSP_LEVEL, 32'ha);
        rdc(`SMC_REG_RSP_DATA, IDENT);
        rdc(`SMC_REG_RSP_LEVEL, 32'h7);
        rdc(`SMC_REG_RSP_DATA, 32'h0900_0000);
        rdc(`SMC_REG_RSP_LEVEL, 32'h0);
        $display("test fill and drain done");
        wr(`SMC_REG_IRQ_MASK, 32'h1);
        rdc(`SMC_REG_IRQ_FLAGS, 32'h2);
        chk(irq_o, 35'h0);
        wr(`SMC_REG_CMD_LAST, 32'h0300_0000);
        poll(`SMC_REG_RSP_LEVEL, 32'h7);
        chk(irq_o, 35'h1);
        rdc(`SMC_REG_RSP_DATA, 32'h0300_0000);
        wr(`SMC_REG_IRQ_MASK, 32'h0);
        rdc(`SMC_REG_IRQ_FLAGS, 32'h2);
        chk(irq_o, 35'h0);
        wr(`SMC_REG_IRQ_MASK, 32'h2);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        @(posedge clk_i);
        resetn_i <= 1'b1;
        rdc(`SMC_REG_IRQ_MASK, 32'h0);
        $display("test masking and reset done");
        finish_test();
    end
endmodule
